//--- hw/scp_map.svh
// constants for the sensor command/status parameter bank
//
// Summary of operation
// - system command write acts at once: 128 reset, 130 factory reset, 162 teach.
// - code 163 stores settings persistently, taking up to 600 ms.
// - while storing, no further data or telegrams are accepted.
// - status word low twelve bits hold the measurement cycle number.
// - status bits twelve and thirteen are reserved, read zero.
// - status bit fourteen is set when operating status changes.
// - event reason is readable from parameter index 2162.
// - status bit fifteen is one while a valid result exists.
// - teach status reads 0 ok, 1 busy, 128 error; starts at 0.
// - alignment record reports first and last beam signal levels.
// - last beam level sits in bits 31..16, default zero.
// - first beam level sits in bits 15..0, default zero.
`ifndef SCP_MAP_SVH
`define SCP_MAP_SVH

// ==========================================================
// parameter indices
`define SCP_IDX_SYSTEM_COMMAND   16'h0002
`define SCP_IDX_TEACH_RESULT     16'h0045
`define SCP_IDX_ALIGNMENT        16'h0046
`define SCP_IDX_STATE_WORD       16'h00A2
`define SCP_IDX_EVENT_REASON     16'h0872

// ==========================================================
// command codes
`define SCP_CMD_RESET            8'h80
`define SCP_CMD_FACTORY          8'h82
`define SCP_CMD_TEACH            8'hA2
`define SCP_CMD_SAVE             8'hA3

// ==========================================================
// teach result codes
`define SCP_TEACH_OK             8'h00
`define SCP_TEACH_BUSY           8'h01
`define SCP_TEACH_ERR            8'h80

// ==========================================================
// field positions
`define SCP_CYCLE_MSB            11
`define SCP_EVENT_BIT            14
`define SCP_VALID_BIT            15
`define SCP_LAST_LSB             16

// ==========================================================
// timing
`define SCP_CLK_HZ               50000000
`define SCP_SAVE_MS              600
`define SCP_SAVE_CYCLES          ((`SCP_CLK_HZ / 1000) * `SCP_SAVE_MS)

`endif

//--- hw/scp_pkg.sv
// types for the sensor command/status parameter bank
`default_nettype none
package scp_pkg;
	typedef enum logic [1:0] {
		SCP_IDLE  = 2'b00,
		SCP_TEACH = 2'b01,
		SCP_SAVE  = 2'b10
	} scp_state_t;
endpackage
`default_nettype wire

//--- hw/scp_bank.sv
// parameter bank: system command, status word, teach result, alignment
`timescale 1ns/1ps
`default_nettype none
`include "scp_map.svh"

module scp_bank
	import scp_pkg::*;
#(
	parameter int SAVE_CYCLES = `SCP_SAVE_CYCLES
) (
	// clock and reset
	input  wire logic        I_CLK,
	input  wire logic        I_RSTN,
	// parameter access from the link layer
	input  wire logic        i_req,
	input  wire logic        i_wr,
	input  wire logic [15:0] i_index,
	input  wire logic [7:0]  i_wdata,
	output logic             o_ack,
	output logic             o_nack,
	output logic             o_busy,
	output logic [31:0]      o_rdata,
	// measurement core
	input  wire logic        i_meas_done,
	input  wire logic [11:0] i_meas_cycle,
	input  wire logic        i_meas_valid,
	input  wire logic [7:0]  i_op_status,
	input  wire logic [15:0] i_first_raw,
	input  wire logic [15:0] i_last_raw,
	input  wire logic [1:0]  i_reserve_shift,
	input  wire logic        i_teach_done,
	input  wire logic        i_teach_fail,
	// command strobes to the device
	output logic             o_dev_reset,
	output logic             o_factory_reset,
	output logic             o_teach_start,
	output logic             o_store_start
);

	// ==========================================================
	// access timing as seen by the link layer
	//  - a request is taken on the edge where i_req is high, one edge per access
	//  - exactly one of o_ack and o_nack answers on the next edge, for one cycle
	//  - read data stands beside the ack for that cycle and is zero otherwise
	//  - command strobes go out beside the ack, so the device acts at once
	//  - unknown indices and writes to anything but the command are refused
	//  - codes outside the four commands are refused and change nothing
	//  - a store locks the bank: every request is refused until o_busy falls
	//  - the event bit clears on a taken read of the state word; a change wins
	// after reset all outputs are low, the teach result is ok, both levels zero
	// the store time is counted on the one clock, so SAVE_CYCLES has to follow
	// the clock rate; the default assumes the 50 MHz system clock

	// ==========================================================
	// state
	scp_state_t  state;
	logic [31:0] save_cnt;
	logic [11:0] cycle_num;
	logic        valid;
	logic        event_flag;
	logic [7:0]  event_reason;
	logic [7:0]  op_status_q;
	logic [7:0]  teach_result;
	logic [15:0] first_lvl;
	logic [15:0] last_lvl;

	// scaling by reserve: higher reserve lowers the reported level
	// a plain shift keeps the scaling free of multipliers; the reserve code
	// is the shift count, so code 3 divides the level by eight
	function automatic logic [15:0] scale_lvl(input logic [15:0] raw, input logic [1:0] sh);
		scale_lvl = raw >> sh;
	endfunction

	// ==========================================================
	// decode
	wire storing   = (state == SCP_SAVE);
	wire acc       = i_req && !storing;
	wire wr_cmd    = acc && i_wr && (i_index == `SCP_IDX_SYSTEM_COMMAND);
	wire cmd_ok    = (i_wdata == `SCP_CMD_RESET) || (i_wdata == `SCP_CMD_FACTORY) ||
	                 (i_wdata == `SCP_CMD_TEACH) || (i_wdata == `SCP_CMD_SAVE);
	wire cmd_go    = wr_cmd && cmd_ok;
	// one decode per command, shared by the strobes and the sequencer;
	// a telegram during a store never reaches here, acc already blocks it
	wire go_reset   = cmd_go && (i_wdata == `SCP_CMD_RESET);
	wire go_factory = cmd_go && (i_wdata == `SCP_CMD_FACTORY);
	wire go_teach   = cmd_go && (i_wdata == `SCP_CMD_TEACH);
	wire go_save    = cmd_go && (i_wdata == `SCP_CMD_SAVE);
	// a teach is still open while its result reads busy and no end is seen
	wire teach_end  = i_teach_done || i_teach_fail;
	wire teach_open = (teach_result == `SCP_TEACH_BUSY) && !teach_end;
	wire rd_state  = acc && !i_wr && (i_index == `SCP_IDX_STATE_WORD);
	wire rd_known  = (i_index == `SCP_IDX_STATE_WORD) || (i_index == `SCP_IDX_TEACH_RESULT) ||
	                 (i_index == `SCP_IDX_ALIGNMENT) || (i_index == `SCP_IDX_EVENT_REASON);
	wire good      = cmd_go || (acc && !i_wr && rd_known);
	wire st_change = (i_op_status != op_status_q);
	wire [15:0] state_word = {valid, event_flag, 2'b00, cycle_num};
	wire [31:0] align_word = {last_lvl, first_lvl};

	wire [31:0] next_rdata =
		(i_index == `SCP_IDX_STATE_WORD)   ? {16'h0000, state_word} :
		(i_index == `SCP_IDX_TEACH_RESULT) ? {24'h000000, teach_result} :
		(i_index == `SCP_IDX_ALIGNMENT)    ? align_word :
		(i_index == `SCP_IDX_EVENT_REASON) ? {24'h000000, event_reason} : 32'h00000000;

	// ==========================================================
	// access answer; a request during storing is refused
	always_ff @(posedge I_CLK or negedge I_RSTN) begin
		if (!I_RSTN) begin
			o_ack   <= 1'b0;
			o_nack  <= 1'b0;
			o_rdata <= 32'h00000000;
		end else begin
			o_ack   <= good;
			o_nack  <= i_req && !good;
			o_rdata <= (acc && !i_wr) ? next_rdata : 32'h00000000;
		end
	end

	// command strobes, one cycle each, issued at once
	always_ff @(posedge I_CLK or negedge I_RSTN) begin
		if (!I_RSTN) begin
			o_dev_reset     <= 1'b0;
			o_factory_reset <= 1'b0;
			o_teach_start   <= 1'b0;
			o_store_start   <= 1'b0;
		end else begin
			o_dev_reset     <= go_reset;
			o_factory_reset <= go_factory;
			o_teach_start   <= go_teach;
			o_store_start   <= go_save;
		end
	end

	// ==========================================================
	// teach/save sequencer; save holds the bank busy for the full store time
	// a save may arrive while a teach runs: the store lock must still apply,
	// otherwise telegrams would be taken during the store; once the store
	// is over the sequencer goes back to tracking the open teach
	always_ff @(posedge I_CLK or negedge I_RSTN) begin
		if (!I_RSTN) begin
			state    <= SCP_IDLE;
			save_cnt <= 32'h00000000;
			o_busy   <= 1'b0;
		end else begin
			unique case (state)
				SCP_IDLE, SCP_TEACH: begin
					if (go_save) begin
						state    <= SCP_SAVE;
						save_cnt <= 32'(SAVE_CYCLES - 1);
						o_busy   <= 1'b1;
					end else if (go_teach) begin
						state <= SCP_TEACH;
					end else if ((state == SCP_TEACH) && teach_end) begin
						state <= SCP_IDLE;
					end
				end
				SCP_SAVE: begin
					if (save_cnt == 32'h00000000) begin
						state  <= teach_open ? SCP_TEACH : SCP_IDLE;
						o_busy <= 1'b0;
					end else begin
						save_cnt <= save_cnt - 32'h00000001;
					end
				end
				default: state <= SCP_IDLE;
			endcase
		end
	end

	// teach result follows the teach, even when a store runs meanwhile
	always_ff @(posedge I_CLK or negedge I_RSTN) begin
		if (!I_RSTN) begin
			teach_result <= `SCP_TEACH_OK;
		end else if (go_teach) begin
			teach_result <= `SCP_TEACH_BUSY;
		end else if (teach_end && (teach_result == `SCP_TEACH_BUSY)) begin
			teach_result <= i_teach_fail ? `SCP_TEACH_ERR : `SCP_TEACH_OK;
		end
	end

	// ==========================================================
	// measurement status; event set wins over clear-on-read
	// only a taken read clears the flag: a read refused during a store
	// leaves it standing, so no event is lost
	always_ff @(posedge I_CLK or negedge I_RSTN) begin
		if (!I_RSTN) begin
			cycle_num    <= 12'h000;
			valid        <= 1'b0;
			event_flag   <= 1'b0;
			event_reason <= 8'h00;
			op_status_q  <= 8'h00;
		end else begin
			op_status_q <= i_op_status;
			valid       <= i_meas_valid;
			if (i_meas_done)
				cycle_num <= i_meas_cycle;
			if (st_change) begin
				event_flag   <= 1'b1;
				event_reason <= i_op_status;
			end else if (rd_state) begin
				event_flag   <= 1'b0;
			end
		end
	end

	// alignment levels latched per measurement, reserve-scaled
	// both halves move on the same edge, so a read never mixes the first
	// and last beam of two different measurements
	always_ff @(posedge I_CLK or negedge I_RSTN) begin
		if (!I_RSTN) begin
			first_lvl <= 16'h0000;
			last_lvl  <= 16'h0000;
		end else if (i_meas_done) begin
			first_lvl <= scale_lvl(i_first_raw, i_reserve_shift);
			last_lvl  <= scale_lvl(i_last_raw, i_reserve_shift);
		end
	end

endmodule
`default_nettype wire

//--- verification/scp_bank_asserts.sv
// concurrent checks on the parameter bank ports
`timescale 1ns/1ps
`default_nettype none
`include "scp_map.svh"
module scp_bank_asserts #(parameter int SAVE_CYCLES = `SCP_SAVE_CYCLES) (
	// watched ports
	input wire logic        I_CLK,
	input wire logic        I_RSTN,
	input wire logic        i_req,
	input wire logic        i_wr,
	input wire logic [15:0] i_index,
	input wire logic [7:0]  i_wdata,
	input wire logic        o_ack,
	input wire logic        o_nack,
	input wire logic        o_busy,
	input wire logic [31:0] o_rdata,
	input wire logic        o_dev_reset,
	input wire logic        o_factory_reset,
	input wire logic        o_teach_start,
	input wire logic        o_store_start
);
	default clocking @(posedge I_CLK); endclocking
	default disable iff (!I_RSTN);
	// ==========
	// decode of command writes, store length count
	wire       cmd = i_req && i_wr && i_index == `SCP_IDX_SYSTEM_COMMAND && !o_busy;
	wire [3:0] hit = {i_wdata == `SCP_CMD_RESET, i_wdata == `SCP_CMD_FACTORY, i_wdata == `SCP_CMD_TEACH,
		i_wdata == `SCP_CMD_SAVE};
	wire [3:0] stb = {o_dev_reset, o_factory_reset, o_teach_start, o_store_start};
	wire       rd  = i_req && !i_wr;
	wire       rd_sw = rd && i_index == `SCP_IDX_STATE_WORD;
	wire       rd_tr = rd && i_index == `SCP_IDX_TEACH_RESULT;
	int        busy_len;
	always_ff @(posedge I_CLK or negedge I_RSTN) begin
		if (!I_RSTN) busy_len <= 0;
		else busy_len <= o_busy ? busy_len + 1 : 0;
	end
	AST_ANSWER: assert property (i_req |=> o_ack != o_nack) else $error("no single answer");
	AST_STROBE: assert property (cmd && |hit |=> o_ack && stb == $past(hit)) else $error("bad strobe");
	AST_BADCMD: assert property (cmd && !(|hit) |=> o_nack && stb == 4'h0) else $error("bad cmd taken");
	AST_REFUSE: assert property (i_req && o_busy |=> o_nack) else $error("taken while busy");
	AST_SAVEBUSY: assert property (cmd && hit[0] |=> o_busy [*8]) else $error("store too short");
	AST_SAVELEN: assert property (busy_len <= SAVE_CYCLES) else $error("store too long");
	AST_SAVEEND: assert property ($fell(o_busy) |-> busy_len == SAVE_CYCLES) else $error("store length wrong");
	AST_LOCKED: assert property (o_busy && $past(o_busy) |-> stb == 4'h0) else $error("command acted in store");
	AST_RDZERO: assert property (!(o_ack && $past(rd)) |-> o_rdata == 32'h0) else $error("stray read data");
	AST_RSVD: assert property (o_ack && $past(rd_sw) |-> o_rdata[31:16] == '0 && o_rdata[13:12] == '0)
		else $error("reserved bits set");
	AST_TEACHRD: assert property (o_ack && $past(rd_tr) |->
		o_rdata inside {32'h0, 32'h1, 32'h80}) else $error("bad teach code");
	// main scenarios reached
	COV_STORE: cover property (o_store_start);
	COV_TEACH: cover property (o_teach_start);
	COV_REFUSE: cover property (i_req && o_busy ##1 o_nack);
	COV_TEACH_STORE: cover property (o_teach_start ##[1:8] o_store_start);
endmodule
bind scp_bank scp_bank_asserts #(.SAVE_CYCLES(SAVE_CYCLES)) u_asserts (.*);
`default_nettype wire

//--- verification/scp_master.sv
// link master model issuing parameter accesses
`timescale 1ns/1ps
`default_nettype none
module scp_master (
	input wire logic        clk,
	input wire logic        ack,
	input wire logic        nack,
	input wire logic        busy,
	input wire logic [31:0] rdata,
	output var logic        req,
	output var logic        wr,
	output var logic [15:0] idx,
	output var logic [7:0]  wd
);
	initial {req, wr, idx, wd} = '0;
	// one access; holds off during a store unless told to push through
	task automatic acc(input logic w, input logic [15:0] i, input logic [7:0] c, input bit f,
		output logic [1:0] an, output logic [31:0] d);
		for (int n = 0; n < 100 && busy && !f; n++) @(posedge clk);
		@(posedge clk);
		#1 {req, wr, idx, wd} = {1'b1, w, i, c};
		@(posedge clk);
		#1 {req, wr, idx, wd} = {1'b0, ~w, ~i, ~c}; // released lines show no stale value
		an = {nack, ack};
		d = rdata;
	endtask
endmodule
`default_nettype wire

//--- verification/test_sensor_command_status_params.sv
// bench for the parameter bank: reads, commands, teach, store
`timescale 1ns/1ps
`default_nettype none
module test_sensor_command_status_params;
	logic        clk = 0, rstn = 0, req, wr, ack, nack, busy, done = 0, valid = 0, t_ok = 0, t_bad = 0;
	logic [15:0] idx, first = 16'h1234, last = 16'hF00F;
	logic [11:0] cyc = 12'hABC;
	logic [7:0]  wd, op = 8'h00;
	logic [31:0] rdata, d;
	logic [1:0]  sh = 2'h0, an;
	wire  [3:0]  stb;
	int          num_errors = 0, n_compared = 0;
	always #10 clk = ~clk;
	scp_bank #(.SAVE_CYCLES(20)) dut (.I_CLK(clk), .I_RSTN(rstn), .i_req(req), .i_wr(wr), .i_index(idx),
		.i_wdata(wd), .o_ack(ack), .o_nack(nack), .o_busy(busy), .o_rdata(rdata), .i_meas_done(done),
		.i_meas_cycle(cyc), .i_meas_valid(valid), .i_op_status(op), .i_first_raw(first), .i_last_raw(last),
		.i_reserve_shift(sh), .i_teach_done(t_ok), .i_teach_fail(t_bad), .o_dev_reset(stb[3]),
		.o_factory_reset(stb[2]), .o_teach_start(stb[1]), .o_store_start(stb[0]));
	scp_master m (.clk(clk), .ack(ack), .nack(nack), .busy(busy), .rdata(rdata), .req(req), .wr(wr),
		.idx(idx), .wd(wd));
	// ==========
	// compare, access and pulse helpers
	task automatic chk(input logic [33:0] got, input logic [33:0] exp);
		n_compared++;
		if (got !== exp) begin
			num_errors++;
			$display("FAIL t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask
	task automatic rd(input logic [15:0] i, input logic [31:0] e);
		m.acc(1'b0, i, 8'h00, 1'b0, an, d);
		chk({an, d}, {2'b01, e});
	endtask
	task automatic wr_cmd(input logic [7:0] c, input logic [1:0] ea, input logic [3:0] es);
		m.acc(1'b1, 16'h0002, c, 1'b0, an, d);
		chk({28'h0, an, stb}, {28'h0, ea, es});
	endtask
	// one-cycle pulse on {done, t_ok, t_bad}
	task automatic pul(input logic [2:0] s);
		@(posedge clk);
		#1 {done, t_ok, t_bad} = s;
		@(posedge clk);
		#1 {done, t_ok, t_bad} = 3'b000;
	endtask
	task automatic stop_test;
		if (num_errors == 0 && n_compared > 0) begin
			$display("Finished cleanly");
		end else begin
			$display("Finished with errors");
		end
		$finish;
	endtask
	// ==========
	// main sequence
	initial begin
		repeat (20) @(posedge clk);
		#1 rstn = 1;
		rd(16'h0045, 32'h0);
		rd(16'h0046, 32'h0);
		op = 8'h05;
		valid = 1;
		pul(3'b100);
		rd(16'h00A2, 32'hCABC);
		rd(16'h00A2, 32'h8ABC);
		rd(16'h0872, 32'h05);
		rd(16'h0046, 32'hF00F1234);
		sh = 2'h2;
		cyc = 12'h123;
		valid = 0;
		pul(3'b100);
		rd(16'h0046, 32'h3C03048D);
		rd(16'h00A2, 32'h0123);
		wr_cmd(8'hA2, 2'b01, 4'b0010);
		rd(16'h0045, 32'h1);
		pul(3'b001);
		rd(16'h0045, 32'h80);
		wr_cmd(8'hA2, 2'b01, 4'b0010);
		pul(3'b010);
		wr_cmd(8'h81, 2'b10, 4'b0000);
		rd(16'h0045, 32'h0);
		wr_cmd(8'h80, 2'b01, 4'b1000);
		wr_cmd(8'h82, 2'b01, 4'b0100);
		wr_cmd(8'hA3, 2'b01, 4'b0001);
		m.acc(1'b0, 16'h00A2, 8'h00, 1'b1, an, d);
		chk({31'h0, busy, an}, {31'h0, 1'b1, 2'b10});
		m.acc(1'b0, 16'h00A2, 8'h00, 1'b0, an, d);
		chk({31'h0, busy, an}, {31'h0, 1'b0, 2'b01});
		// store while a teach runs: still locked, teach outcome kept
		wr_cmd(8'hA2, 2'b01, 4'b0010);
		wr_cmd(8'hA3, 2'b01, 4'b0001);
		m.acc(1'b1, 16'h0002, 8'h80, 1'b1, an, d);
		chk({28'h0, an, stb}, {28'h0, 2'b10, 4'b0000});
		pul(3'b001);
		rd(16'h0045, 32'h80);
		stop_test();
	end
	// hang guard, far beyond the hundred or so cycles needed
	initial begin
		#100000;
		num_errors++;
		stop_test();
	end
endmodule
`default_nettype wire
